// file: lrt_pkg.sv
package lrt_pkg;
  // Register byte addresses.
  localparam logic [9:0] ADDR_SEC = 10'h200;
  localparam logic [9:0] ADDR_MIN = 10'h201;
  localparam logic [9:0] ADDR_HOUR = 10'h202;
  localparam logic [9:0] ADDR_DATE = 10'h203;
  localparam logic [9:0] ADDR_MONTH = 10'h204;
  localparam logic [9:0] ADDR_YEAR = 10'h205;
  localparam logic [9:0] ADDR_RATE_LO = 10'h206;
  localparam logic [9:0] ADDR_RATE_HI = 10'h207;
  localparam logic [9:0] ADDR_THR_LO = 10'h208;
  localparam logic [9:0] ADDR_THR_HI = 10'h209;
  localparam logic [9:0] ADDR_RES_LO = 10'h20c;
  localparam logic [9:0] ADDR_RES_HI = 10'h20d;
  localparam logic [9:0] ADDR_ALM_EN = 10'h210;
  localparam logic [9:0] ADDR_RTC_CTL = 10'h212;
  // Field positions.
  localparam int HOUR_12_BIT = 6;
  localparam int HOUR_PM_BIT = 5;
  localparam int CENTURY_BIT = 7;
  localparam int LOW_EN_BIT = 0;
  localparam int HIGH_EN_BIT = 1;
  localparam int OSC_EN_BIT = 0;
  localparam int FAST_UNIT_BIT = 1;
  // Writable masks of the clock and control bytes, then the valid result low bits; zero bits read back zero.
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h7f;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h9f;
  localparam logic [7:0] MASK_RATE_HI = 8'h3f;
  localparam logic [7:0] MASK_ALM_EN = 8'h03;
  localparam logic [7:0] MASK_RTC_CTL = 8'h03;
  localparam logic [7:0] MASK_RES_LO = 8'he0;
  // Values after reset.
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_RATE_LO = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Timing: one second at the 40 MHz clock; seconds per minute.
  localparam int CLK_HZ = 40000000;
  localparam int SEC_NS = 1000000000;
  localparam int CLK_NS = 25;
  localparam int CYCLES_PER_SEC = SEC_NS / CLK_NS;
  localparam logic [5:0] SECS_PER_MIN = 6'd60;
endpackage

// file: lrt_rtc.sv
`timescale 1ns/100ps
// Overview of operation
// R1: Seconds to year held in six consecutive BCD register bytes.
// R2: Host reads clock bytes in one pass starting at seconds.
// R3: Fixed-zero clock bits always read zero whatever is written.
// R4: Hours bit 6 set selects 12-hour, clear selects 24-hour counting.
// R5: Hours bit 5 is PM in 12-hour mode, twenties digit in 24-hour.
// R6: Month bit 7 century is writable and toggles on year 99 to 00.
// R7: February 29 exists in every year divisible by four, including 00.
// R8: Sample interval counts seconds if fast unit set, else minutes.
// R9: Interval is 14-bit, 1 to 16383; top high-byte bits read zero.
// R10: Host never programs a zero sample interval.
// R11: Host sets the unit bit together with the sample interval.
// R12: Interval bytes are read-only while a mission runs.
// R13: Result high byte valid; 16-bit low byte top three bits only.
// R14: Result codes unsigned, 0.5 or 0.0625 degree steps.
// R15: Under-range gives all zero, over-range all ones in valid bits.
// R16: Stored and latest readings share one byte encoding.
// R17: Thresholds are one byte in half-degree steps, same offset.
// R18: Alarm compare uses only the result high byte.
// R19: Alarm raised only for alarming value with its enable set.
// R20: In mission, low enable and result at or below low sets low flag.
// R21: In mission, high enable and result at or above high sets flag.
// R22: Alarm enable byte read-only in mission, bits 2 to 7 zero.
// R23: Running oscillator advances seconds each second with full carries.
// R24: Oscillator enable clear stops clock; no conversion while stopped.
module lrt_rtc #(
  parameter int CYCLES_PER_SEC = lrt_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Register access from the link layer
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [9:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // Mission and conversion interface
  input wire logic i_mission_active,
  input wire logic i_log_width_select,
  input wire logic i_conv_done,
  input wire logic [10:0] i_conv_code,
  input wire logic i_conv_under,
  input wire logic i_conv_over,
  input wire logic i_flags_clear,
  // Outputs to the mission logic
  output logic o_sample_tick,
  output logic o_low_alarm_flag,
  output logic o_high_alarm_flag,
  output logic o_oscillator_enable
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] sec, min, hour, date, month, year;
  logic [7:0] rate_lo, rate_hi, thr_lo, thr_hi;
  logic [7:0] result_low_byte, result_high_byte;
  logic [7:0] alm_en, rtc_ctl;
  logic [25:0] presc;
  logic sec_tick;
  logic [5:0] min_presc;
  logic unit_tick;
  logic [13:0] rate_cnt;
  logic low_alarm_enable, high_alarm_enable;
  logic fast_sample_unit, oscillator_enable;
  logic wr_clock;
  assign low_alarm_enable = alm_en[lrt_pkg::LOW_EN_BIT];
  assign high_alarm_enable = alm_en[lrt_pkg::HIGH_EN_BIT];
  assign fast_sample_unit = rtc_ctl[lrt_pkg::FAST_UNIT_BIT];
  assign oscillator_enable = rtc_ctl[lrt_pkg::OSC_EN_BIT];
  // Clock bytes are held off during a mission as the interval is.
  assign wr_clock = i_reg_wr && !i_mission_active;

  // ****************************************************************
  // BCD helpers
  // ****************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction
  // Last valid day of the month in BCD, February checked for leap year.
  function automatic logic [7:0] month_last(input logic [4:0] m,
                                            input logic [7:0] y);
    logic [7:0] r;
    logic leap;
    r = 8'h31;
    // Divisible by four in BCD: tens even with units 0,4,8, or odd 2,6.
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                  (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: r = leap ? 8'h29 : 8'h28; // [R7]
      5'h04, 5'h06, 5'h09, 5'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Second prescaler and oscillator gating
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      presc <= '0;
      sec_tick <= 1'b0;
    end else if (!oscillator_enable) begin
      presc <= '0; // [R24]
      sec_tick <= 1'b0;
    end else if (presc == 26'(CYCLES_PER_SEC - 1)) begin
      presc <= '0;
      sec_tick <= 1'b1; // [R23]
    end else begin
      presc <= presc + 26'h1;
      sec_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // Calendar
  // ****************************************************************
  logic sec_wrap, min_wrap, hour_wrap, date_wrap, month_wrap;
  logic [7:0] next_hour;
  logic h12;
  assign h12 = hour[lrt_pkg::HOUR_12_BIT];
  assign sec_wrap = sec_tick && sec == 8'h59;
  assign min_wrap = sec_wrap && min == 8'h59;
  assign hour_wrap = min_wrap && (h12 ?
      (hour[5:0] == 6'h31) : (hour[5:0] == 6'h23));
  assign date_wrap = hour_wrap && date == month_last(month[4:0], year);
  assign month_wrap = date_wrap && month[4:0] == 5'h12;
  // Hour step: 12-hour counts 12,1..11 with PM flipping at 11 to 12.
  always_comb begin
    next_hour = hour;
    if (h12) begin // [R4]
      if (hour[4:0] == 5'h12) begin
        next_hour = {hour[7:5], 5'h01};
      end else if (hour[4:0] == 5'h11) begin
        next_hour = {hour[7:6], ~hour[5], 5'h12}; // [R5]
      end else begin
        next_hour = {hour[7:5], 5'(bcd_inc({3'b000, hour[4:0]}))};
      end
    end else begin
      // Bits 5 and 4 together form the tens digit of 24-hour time.
      if (hour[5:0] == 6'h23) begin
        next_hour = {hour[7:6], 6'h00}; // [R5]
      end else begin
        next_hour = {hour[7:6], 6'(bcd_inc({2'b00, hour[5:0]}))};
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sec <= lrt_pkg::RST_ZERO;
      min <= lrt_pkg::RST_ZERO;
      hour <= lrt_pkg::RST_ZERO;
      date <= lrt_pkg::RST_DATE;
      month <= lrt_pkg::RST_MONTH;
      year <= lrt_pkg::RST_ZERO;
    end else if (wr_clock && i_reg_addr == lrt_pkg::ADDR_SEC) begin
      sec <= i_reg_wdata & lrt_pkg::MASK_SEC; // [R3]
    end else if (wr_clock && i_reg_addr == lrt_pkg::ADDR_MIN) begin
      min <= i_reg_wdata & lrt_pkg::MASK_MIN; // [R3]
    end else if (wr_clock && i_reg_addr == lrt_pkg::ADDR_HOUR) begin
      hour <= i_reg_wdata & lrt_pkg::MASK_HOUR; // [R3] [R4]
    end else if (wr_clock && i_reg_addr == lrt_pkg::ADDR_DATE) begin
      date <= i_reg_wdata & lrt_pkg::MASK_DATE; // [R3]
    end else if (wr_clock && i_reg_addr == lrt_pkg::ADDR_MONTH) begin
      month <= i_reg_wdata & lrt_pkg::MASK_MONTH; // [R3] [R6]
    end else if (wr_clock && i_reg_addr == lrt_pkg::ADDR_YEAR) begin
      year <= i_reg_wdata;
    end else if (sec_tick) begin
      sec <= sec_wrap ? 8'h00 : bcd_inc(sec); // [R1] [R23]
      if (sec_wrap) begin
        min <= min_wrap ? 8'h00 : bcd_inc(min);
      end
      if (min_wrap) begin
        hour <= next_hour;
      end
      if (hour_wrap) begin
        date <= date_wrap ? 8'h01 : bcd_inc(date);
      end
      if (date_wrap) begin
        month[4:0] <= month_wrap ? 5'h01 : 5'(bcd_inc({3'b000, month[4:0]}));
      end
      if (month_wrap) begin
        year <= (year == 8'h99) ? 8'h00 : bcd_inc(year);
        if (year == 8'h99) begin
          month[lrt_pkg::CENTURY_BIT] <= ~month[lrt_pkg::CENTURY_BIT]; // [R6]
        end
      end
    end
  end

  // ****************************************************************
  // Sample interval and control bytes
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rate_lo <= lrt_pkg::RST_RATE_LO;
      rate_hi <= lrt_pkg::RST_ZERO;
      alm_en <= lrt_pkg::RST_ZERO;
      rtc_ctl <= lrt_pkg::RST_ZERO;
      thr_lo <= lrt_pkg::RST_ZERO;
      thr_hi <= lrt_pkg::RST_ZERO;
    end else if (wr_clock) begin
      case (i_reg_addr)
        lrt_pkg::ADDR_RATE_LO: rate_lo <= i_reg_wdata; // [R12]
        lrt_pkg::ADDR_RATE_HI: begin
          rate_hi <= i_reg_wdata & lrt_pkg::MASK_RATE_HI; // [R9] [R12]
        end
        lrt_pkg::ADDR_THR_LO: thr_lo <= i_reg_wdata; // [R17]
        lrt_pkg::ADDR_THR_HI: thr_hi <= i_reg_wdata; // [R17]
        lrt_pkg::ADDR_ALM_EN: begin
          alm_en <= i_reg_wdata & lrt_pkg::MASK_ALM_EN; // [R22]
        end
        lrt_pkg::ADDR_RTC_CTL: begin
          rtc_ctl <= i_reg_wdata & lrt_pkg::MASK_RTC_CTL; // [R24]
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Sample interval timer
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      min_presc <= '0;
      unit_tick <= 1'b0;
    end else if (sec_tick) begin
      if (fast_sample_unit) begin
        unit_tick <= 1'b1; // [R8]
        min_presc <= '0;
      end else if (min_presc == lrt_pkg::SECS_PER_MIN - 6'd1) begin
        unit_tick <= 1'b1; // [R8]
        min_presc <= '0;
      end else begin
        unit_tick <= 1'b0;
        min_presc <= min_presc + 6'd1;
      end
    end else begin
      unit_tick <= 1'b0;
    end
  end
  // Counts units down from the interval; a zero interval is the host's
  // fault and here simply yields a tick every unit.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rate_cnt <= 14'h0001;
      o_sample_tick <= 1'b0;
    end else if (!i_mission_active) begin
      rate_cnt <= {rate_hi[5:0], rate_lo}; // [R9] [R10]
      o_sample_tick <= 1'b0;
    end else if (unit_tick) begin
      if (rate_cnt <= 14'h0001) begin
        rate_cnt <= {rate_hi[5:0], rate_lo}; // [R8]
        o_sample_tick <= 1'b1;
      end else begin
        rate_cnt <= rate_cnt - 14'h0001;
        o_sample_tick <= 1'b0;
      end
    end else begin
      o_sample_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // Latest conversion result
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      result_high_byte <= lrt_pkg::RST_ZERO;
      result_low_byte <= lrt_pkg::RST_ZERO;
    end else if (i_conv_done) begin
      if (i_conv_under) begin
        result_high_byte <= 8'h00; // [R15]
        result_low_byte <= 8'h00;
      end else if (i_conv_over) begin
        result_high_byte <= 8'hff; // [R15]
        result_low_byte <= lrt_pkg::MASK_RES_LO;
      end else begin
        result_high_byte <= i_conv_code[10:3]; // [R13] [R14] [R16]
        // In 8-bit mode the low byte is left as zeros.
        result_low_byte <= i_log_width_select ?
            {i_conv_code[2:0], 5'h00} : 8'h00; // [R13]
      end
    end
  end

  // ****************************************************************
  // Temperature alarm flags
  // ****************************************************************
  logic [7:0] cmp_byte;
  logic low_hit, high_hit;
  always_comb begin
    cmp_byte = i_conv_code[10:3];
    if (i_conv_under) begin
      cmp_byte = 8'h00;
    end else if (i_conv_over) begin
      cmp_byte = 8'hff;
    end
  end
  assign low_hit = cmp_byte <= thr_lo; // [R18]
  assign high_hit = cmp_byte >= thr_hi; // [R18]
  // A new alarm in the clearing cycle wins over the clear.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_low_alarm_flag <= 1'b0;
      o_high_alarm_flag <= 1'b0;
    end else begin
      if (i_conv_done && i_mission_active && low_alarm_enable && low_hit) begin
        o_low_alarm_flag <= 1'b1; // [R19] [R20]
      end else if (i_flags_clear) begin
        o_low_alarm_flag <= 1'b0;
      end
      if (i_conv_done && i_mission_active && high_alarm_enable &&
          high_hit) begin
        o_high_alarm_flag <= 1'b1; // [R19] [R21]
      end else if (i_flags_clear) begin
        o_high_alarm_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_hit <= 1'b0;
      o_oscillator_enable <= 1'b0;
    end else begin
      o_oscillator_enable <= oscillator_enable;
      o_reg_hit <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          lrt_pkg::ADDR_SEC: o_reg_rdata <= sec; // [R2]
          lrt_pkg::ADDR_MIN: o_reg_rdata <= min;
          lrt_pkg::ADDR_HOUR: o_reg_rdata <= hour;
          lrt_pkg::ADDR_DATE: o_reg_rdata <= date;
          lrt_pkg::ADDR_MONTH: o_reg_rdata <= month;
          lrt_pkg::ADDR_YEAR: o_reg_rdata <= year;
          lrt_pkg::ADDR_RATE_LO: o_reg_rdata <= rate_lo;
          lrt_pkg::ADDR_RATE_HI: o_reg_rdata <= rate_hi;
          lrt_pkg::ADDR_THR_LO: o_reg_rdata <= thr_lo;
          lrt_pkg::ADDR_THR_HI: o_reg_rdata <= thr_hi;
          lrt_pkg::ADDR_RES_LO: o_reg_rdata <= result_low_byte;
          lrt_pkg::ADDR_RES_HI: o_reg_rdata <= result_high_byte;
          lrt_pkg::ADDR_ALM_EN: o_reg_rdata <= alm_en;
          lrt_pkg::ADDR_RTC_CTL: o_reg_rdata <= rtc_ctl;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// file: lrt_sensor.sv
`timescale 1ns/100ps
// ****************************************
// Temperature source on the conversion side
// ****************************************
module lrt_sensor (
  // Clock and oscillator state
  input wire logic i_mclk,
  input wire logic i_osc_en,
  // Conversion request from the bench
  input wire logic i_req,
  input wire logic [10:0] i_code,
  input wire logic i_under,
  input wire logic i_over,
  // Conversion result to the block
  output logic o_done,
  output logic [10:0] o_code,
  output logic o_under,
  output logic o_over
);
  logic [10:0] last_code = 11'h000;
  always @(negedge i_mclk) begin
    if (i_req) begin
      last_code <= i_code;
    end
  end
  // A conversion only starts while the oscillator runs.
  assign o_done = i_req & i_osc_en;
  // Idle result lines show garbage so stale values are never trusted.
  assign o_code = i_req ? i_code : ~last_code;
  assign o_under = i_req ? i_under : 1'b1;
  assign o_over = i_req ? i_over : 1'b1;
endmodule

// file: lrt_rtc_chk.sv
`timescale 1ns/100ps
module lrt_rtc_chk #(
  parameter int CYCLES_PER_SEC = 8
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [9:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_mission_active,
  input wire logic i_conv_done,
  input wire logic i_flags_clear,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_hit,
  input wire logic o_sample_tick,
  input wire logic o_low_alarm_flag,
  input wire logic o_high_alarm_flag,
  input wire logic o_oscillator_enable
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_read_answered: assert property (i_reg_rd |=> o_reg_hit)
    else $error("read not answered");
  a_hit_from_read: assert property (o_reg_hit |-> $past(i_reg_rd))
    else $error("hit without read");
  a_rdata_held: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_low_cause: assert property ($rose(o_low_alarm_flag) |->
    $past(i_conv_done && i_mission_active)) else $error("low flag cause");
  a_high_cause: assert property ($rose(o_high_alarm_flag) |->
    $past(i_conv_done && i_mission_active)) else $error("high flag cause");
  a_flags_cleared: assert property (i_flags_clear && !i_conv_done |=>
    !o_low_alarm_flag && !o_high_alarm_flag) else $error("flags kept");
  a_flag_sticky: assert property (o_low_alarm_flag && !i_flags_clear |=>
    o_low_alarm_flag) else $error("low flag lost");
  a_tick_mission: assert property (o_sample_tick |-> $past(i_mission_active))
    else $error("tick outside mission");
  a_tick_gap: assert property (o_sample_tick |=> !o_sample_tick [*7])
    else $error("ticks too close");
  a_osc_write: assert property (i_reg_wr && i_reg_addr == 10'h212 &&
    !i_mission_active |=> ##1
    o_oscillator_enable == $past(i_reg_wdata[0], 2))
    else $error("oscillator bit not written");
  a_mission_lock: assert property (i_reg_wr && i_mission_active |=>
    ##1 $stable(o_oscillator_enable)) else $error("write taken in mission");
endmodule
bind lrt_rtc lrt_rtc_chk #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) lrt_rtc_chk_inst (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_mission_active(i_mission_active), .i_conv_done(i_conv_done),
  .i_flags_clear(i_flags_clear), .o_reg_rdata(o_reg_rdata),
  .o_reg_hit(o_reg_hit), .o_sample_tick(o_sample_tick),
  .o_low_alarm_flag(o_low_alarm_flag), .o_high_alarm_flag(o_high_alarm_flag),
  .o_oscillator_enable(o_oscillator_enable));

// file: lrt_rtc_bench.sv
`timescale 1ns/100ps
module lrt_rtc_bench;
  logic i_mclk, i_sys_rst, i_reg_wr, i_reg_rd, i_mission_active;
  logic i_log_width_select, i_flags_clear, i_conv_done;
  logic i_conv_under, i_conv_over, o_reg_hit, o_sample_tick;
  logic o_low_alarm_flag, o_high_alarm_flag, o_oscillator_enable;
  logic req, req_under, req_over;
  logic [9:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, rv;
  logic [10:0] i_conv_code, req_code;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  lrt_rtc #(.CYCLES_PER_SEC(8)) lrt_rtc_inst (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .i_mission_active(i_mission_active),
    .i_log_width_select(i_log_width_select), .i_conv_done(i_conv_done),
    .i_conv_code(i_conv_code), .i_conv_under(i_conv_under),
    .i_conv_over(i_conv_over), .i_flags_clear(i_flags_clear),
    .o_sample_tick(o_sample_tick), .o_low_alarm_flag(o_low_alarm_flag),
    .o_high_alarm_flag(o_high_alarm_flag),
    .o_oscillator_enable(o_oscillator_enable));
  lrt_sensor lrt_sensor_inst (.i_mclk(i_mclk),
    .i_osc_en(o_oscillator_enable), .i_req(req), .i_code(req_code),
    .i_under(req_under), .i_over(req_over), .o_done(i_conv_done),
    .o_code(i_conv_code), .o_under(i_conv_under), .o_over(i_conv_over));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task finish_test;
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
  endtask
  task rd(input logic [9:0] a);
    @(negedge i_mclk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    rv = (o_reg_hit === 1'b1) ? o_reg_rdata : 8'hxx;
  endtask
  task rdc(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    chk({8'h00, rv}, {8'h00, e});
  endtask
  task wait_tick(input int lim);
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_sample_tick !== 1'b1 && n < lim);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [7:0] e [6];
    e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 6; i++) rdc(10'h200 + 10'(i), e[i]);
    rdc(10'h206, 8'h01);
    rdc(10'h20a, 8'h00);
    repeat (40) @(negedge i_mclk);
    rdc(10'h200, 8'h00);
  endtask
  task t_masks;
    logic [9:0] a [5];
    logic [7:0] e [5];
    a = '{10'h203, 10'h204, 10'h207, 10'h210, 10'h20c};
    e = '{8'h3f, 8'h9f, 8'h3f, 8'h03, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(a[i], 8'hff);
      rdc(a[i], e[i]);
    end
  endtask
  // Sets hh:59:59 with date, month and year, runs one second, stops.
  task rtc_case(input logic [31:0] s, input logic [31:0] e);
    int k;
    wr(10'h212, 8'h00);
    wr(10'h200, 8'h59);
    wr(10'h201, 8'h59);
    for (int i = 0; i < 4; i++) wr(10'h202 + 10'(i), s[31-8*i -: 8]);
    wr(10'h212, 8'h01);
    k = 0;
    do begin
      rd(10'h200);
      k++;
    end while (rv === 8'h59 && k < 40);
    wr(10'h212, 8'h00);
    rdc(10'h200, 8'h00);
    rdc(10'h201, 8'h00);
    for (int i = 0; i < 4; i++) rdc(10'h202 + 10'(i), e[31-8*i -: 8]);
  endtask
  task conv_chk(input logic [10:0] c, input logic u, input logic o,
                input logic [7:0] hi, input logic [7:0] lo,
                input logic [1:0] fl);
    @(negedge i_mclk);
    req = 1'b1;
    req_code = c;
    req_under = u;
    req_over = o;
    @(negedge i_mclk);
    req = 1'b0;
    @(negedge i_mclk);
    chk({14'h0000, o_high_alarm_flag, o_low_alarm_flag}, {14'h0000, fl});
    rdc(10'h20d, hi);
    rdc(10'h20c, lo);
    i_flags_clear = 1'b1;
    @(negedge i_mclk);
    i_flags_clear = 1'b0;
  endtask
  task t_alarms;
    wr(10'h212, 8'h01);
    @(negedge i_mclk);
    chk({15'h0000, o_oscillator_enable}, 16'h0001);
    wr(10'h208, 8'(2 * (-10) + 82));
    wr(10'h209, 8'(51 + 82));
    wr(10'h210, 8'h03);
    i_log_width_select = 1'b1;
    conv_chk(11'h1f0, 1'b0, 1'b0, 8'h3e, 8'h00, 2'h0);
    i_mission_active = 1'b1;
    wr(10'h210, 8'h00);
    rdc(10'h210, 8'h03);
    wr(10'h206, 8'h55);
    rdc(10'h206, 8'h01);
    wr(10'h212, 8'h00);
    rdc(10'h212, 8'h01);
    conv_chk(11'h1f7, 1'b0, 1'b0, 8'h3e, 8'he0, 2'h1);
    conv_chk(11'h1f8, 1'b0, 1'b0, 8'h3f, 8'h00, 2'h0);
    conv_chk(11'h000, 1'b0, 1'b1, 8'hff, 8'he0, 2'h2);
    conv_chk(11'h7ff, 1'b1, 1'b0, 8'h00, 8'h00, 2'h1);
    i_log_width_select = 1'b0;
    conv_chk(11'h42b, 1'b0, 1'b0, 8'h85, 8'h00, 2'h2);
    i_mission_active = 1'b0;
    wr(10'h210, 8'h00);
    i_mission_active = 1'b1;
    conv_chk(11'h000, 1'b1, 1'b0, 8'h00, 8'h00, 2'h0);
    i_mission_active = 1'b0;
  endtask
  task t_ticks;
    // Interval and unit are always written together and never zero.
    wr(10'h206, 8'h02);
    wr(10'h207, 8'h00);
    wr(10'h212, 8'h03);
    i_mission_active = 1'b1;
    wait_tick(200);
    wait_tick(200);
    chk(16'(n), 16'd16);
    i_mission_active = 1'b0;
    wr(10'h206, 8'h01);
    wr(10'h212, 8'h01);
    i_mission_active = 1'b1;
    wait_tick(1200);
    wait_tick(1200);
    chk(16'(n), 16'd480);
    i_mission_active = 1'b0;
  endtask
  initial begin
    {i_reg_wr, i_reg_rd, i_mission_active, i_flags_clear} = 4'h0;
    {req, req_under, req_over, i_log_width_select} = 4'h0;
    i_reg_addr = 10'h200;
    i_reg_wdata = 8'h00;
    req_code = 11'h000;
    i_sys_rst = 1'b1;
    repeat (6) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
    t_masks();
    rtc_case(32'h23280203, 32'h00010303);
    rtc_case(32'h23280204, 32'h00290204);
    rtc_case(32'h23280200, 32'h00290200);
    rtc_case(32'h23300407, 32'h00010507);
    rtc_case(32'h23311299, 32'h00018100);
    rtc_case(32'h51150610, 32'h72150610);
    rtc_case(32'h71150610, 32'h52160610);
    rtc_case(32'h19150610, 32'h20150610);
    rtc_case(32'h50150610, 32'h51150610);
    rtc_case(32'h49150610, 32'h50150610);
    rtc_case(32'h52150610, 32'h41150610);
    t_alarms();
    t_ticks();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    finish_test();
  end
endmodule
